// >>> rtl/ssl_fifo2.sv
// Small word buffer with valid and ready on both sides.
// Assumes one clock; depth and width shape the storage array.
`timescale 1ns/1ps
module ssl_fifo2 #(
    parameter int WIDTH = ssl_pkg::WORD_W,
    parameter int DEPTH = ssl_pkg::FIFO_DEPTH
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);

    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [PW:0] DEPTH_CNT = (PW+1)'(DEPTH);
    localparam logic [PW-1:0] LAST_PTR = PW'(DEPTH - 1);

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [PW-1:0] wr_ptr_r;
    logic [PW-1:0] rd_ptr_r;
    logic [PW:0] count_r;
    logic push;
    logic pop;

    // Honest flags straight from the occupancy count
    assign in_ready = (count_r != DEPTH_CNT);
    assign out_valid = (count_r != '0);
    assign out_data = mem_r[rd_ptr_r];
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;

    // Storage array is written only, never reset
    always_ff @(posedge clk) begin
        if (push) begin
            mem_r[wr_ptr_r] <= in_data;
        end
    end

    // Pointers wrap at the configured depth
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
        end else begin
            if (push) begin
                wr_ptr_r <= (wr_ptr_r == LAST_PTR) ? '0 : wr_ptr_r + 1'b1;
            end
            if (pop) begin
                rd_ptr_r <= (rd_ptr_r == LAST_PTR) ? '0 : rd_ptr_r + 1'b1;
            end
        end
    end

    // Occupancy
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count_r <= '0;
        end else if (push && !pop) begin
            count_r <= count_r + 1'b1;
        end else if (pop && !push) begin
            count_r <= count_r - 1'b1;
        end
    end

    chk_fifo_bounds: assert property (
        @(posedge clk) disable iff (!rst_n)
        count_r <= DEPTH_CNT)
        else $error("buffer occupancy out of range");

endmodule : ssl_fifo2

// >>> rtl/ssl_pkg.sv
// Constants and carrier types for the serial-to-parallel output latch.
// Assumes a 20 MHz system clock and a host that drives the pin clocks.
package ssl_pkg;

    // Widths and layout
    localparam int WORD_W = 8;
    localparam int CASCADE_BIT = 7;
    localparam int FIFO_DEPTH = 2;

    // Reset values
    localparam logic [7:0] SHIFT_RESET = 8'h00;
    localparam logic [7:0] STORE_RESET = 8'h00;
    localparam logic [7:0] DRAIN_LEVEL = 8'h00;

    // Timing: pin pulse width and the system clock period
    localparam int SYS_CLK_PERIOD_NS = 50;
    localparam int PULSE_MIN_NS = 40;
    localparam int SETUP_MIN_NS = 20;
    localparam int HOLD_MIN_NS = 20;
    // The least pulse width rounds up, never below one cycle
    localparam int PULSE_MIN_CYC_RAW =
        (PULSE_MIN_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;
    localparam int PULSE_MIN_CYC =
        (PULSE_MIN_CYC_RAW < 1) ? 1 : PULSE_MIN_CYC_RAW;
    localparam logic [3:0] PULSE_MIN_CNT = 4'(PULSE_MIN_CYC);

    // One latched word on its way to the storage register
    typedef struct packed {
        logic [7:0] bits;
    } ssl_word_t;

    // Latch capture sequencing
    typedef enum logic [0:0] {
        CAP_IDLE = 1'b0,
        CAP_HOLD = 1'b1
    } ssl_cap_state_t;

endpackage : ssl_pkg

// >>> rtl/ssl_shift_stage.sv
// Shift stage that lives on the host's shift clock.
// Assumes the serial input is timed to that clock; clear acts at once.
`timescale 1ns/1ps
module ssl_shift_stage #(
    parameter int WIDTH = ssl_pkg::WORD_W
) (
    input wire logic shift_clk,
    input wire logic rst_n,
    input wire logic clear_n,
    input wire logic serial_in,
    output logic [WIDTH-1:0] stage_r,
    output logic cascade_r
);

    logic clr_n;
    logic shifted_r;

    // Clear and system reset share the asynchronous path; no edge needed
    assign clr_n = rst_n & clear_n;

    // Advance one position per rising edge, serial input into bit 0
    always_ff @(posedge shift_clk or negedge clr_n) begin
        if (!clr_n) begin
            stage_r <= ssl_pkg::SHIFT_RESET;
        end else begin
            stage_r <= {stage_r[WIDTH-2:0], serial_in};
        end
    end

    // Own flop so the chained device sees a clean edge-timed level
    always_ff @(posedge shift_clk or negedge clr_n) begin
        if (!clr_n) begin
            cascade_r <= 1'b0;
        end else begin
            cascade_r <= stage_r[WIDTH-2];
        end
    end

    // Marks that an edge has passed since the last clear or reset, so the
    // advance check never compares against a word that a clear has wiped
    always_ff @(posedge shift_clk or negedge clr_n) begin
        if (!clr_n) begin
            shifted_r <= 1'b0;
        end else begin
            shifted_r <= 1'b1;
        end
    end

    chk_shift_advance: assert property (
        @(posedge shift_clk) disable iff (!clr_n)
        shifted_r |-> stage_r == {$past(stage_r[WIDTH-2:0]),
                                  $past(serial_in)})
        else $error("shift stage did not advance");

    chk_cascade_last: assert property (
        @(posedge shift_clk) disable iff (!clr_n)
        cascade_r == stage_r[WIDTH-1])
        else $error("cascade output differs from last stage");

endmodule : ssl_shift_stage

// >>> rtl/ssl_top.sv
// Serial-to-parallel output latch: shift stage, storage, open-drain outputs.
// Assumes the shift clock stops between frames and the latch clock rises
// only after the last shift edge of a word has settled.
`timescale 1ns/1ps
module ssl_top (
    input wire logic SYS_CLK,
    input wire logic RESETN,
    input wire logic SHIFT_CLOCK,
    input wire logic SERIAL_INPUT,
    input wire logic SHIFT_CLEAR_N,
    input wire logic LATCH_CLOCK,
    input wire logic OUTPUT_ENABLE_N,
    input wire logic [7:0] DRAIN_I,
    output logic [7:0] DRAIN_O,
    output logic [7:0] DRAIN_OE,
    output logic CASCADE_OUTPUT,
    output logic [7:0] DRAIN_FAULT
);

    localparam int W = ssl_pkg::WORD_W;

    // Shift-domain signals
    logic [W-1:0] stage_r;
    logic cascade_r;

    // Synchronisers into the system domain
    logic [W-1:0] word_meta_r;
    logic [W-1:0] word_sync_r;
    logic latch_meta_r;
    logic latch_sync_r;
    logic latch_prev_r;
    logic oe_n_meta_r;
    logic oe_n_sync_r;
    logic clr_n_meta_r;
    logic clr_n_sync_r;
    logic [W-1:0] pin_meta_r;
    logic [W-1:0] pin_sync_r;

    // Latch capture
    logic [3:0] high_cnt_r;
    logic [3:0] high_cnt_nxt;
    logic latch_rise;
    ssl_pkg::ssl_cap_state_t cap_state_r;
    ssl_pkg::ssl_word_t held_r;
    ssl_pkg::ssl_word_t push_word;
    logic push_valid;
    logic push_ready;

    // Buffer drain and storage
    ssl_pkg::ssl_word_t pop_word;
    logic pop_valid;
    logic pop_ready;
    logic store_busy_r;
    logic [W-1:0] storage_r;

    // Output stage
    logic [W-1:0] drain_oe_r;
    logic [W-1:0] drain_o_r;
    logic [W-1:0] oe_d1_r;
    logic [W-1:0] oe_d2_r;
    logic [W-1:0] oe_d3_r;
    logic [W-1:0] fault_r;

    // Logic on the host's shift clock
    ssl_shift_stage #(
        .WIDTH(W)
    ) u_shift (
        .shift_clk(SHIFT_CLOCK),
        .rst_n(RESETN),
        .clear_n(SHIFT_CLEAR_N),
        .serial_in(SERIAL_INPUT),
        .stage_r(stage_r),
        .cascade_r(cascade_r)
    );

    assign CASCADE_OUTPUT = cascade_r;

    // Shift word crosses as a level: it stands still once shifting ends,
    // and the latch edge passes the same two flops, so both arrive together
    always_ff @(posedge SYS_CLK or negedge RESETN) begin
        if (!RESETN) begin
            word_meta_r <= ssl_pkg::SHIFT_RESET;
            word_sync_r <= ssl_pkg::SHIFT_RESET;
        end else begin
            word_meta_r <= stage_r;
            word_sync_r <= word_meta_r;
        end
    end

    // Pin levels: latch clock, output enable, clear
    always_ff @(posedge SYS_CLK or negedge RESETN) begin
        if (!RESETN) begin
            latch_meta_r <= 1'b0;
            latch_sync_r <= 1'b0;
            latch_prev_r <= 1'b0;
            oe_n_meta_r <= 1'b1;
            oe_n_sync_r <= 1'b1;
            clr_n_meta_r <= 1'b1;
            clr_n_sync_r <= 1'b1;
        end else begin
            latch_meta_r <= LATCH_CLOCK;
            latch_sync_r <= latch_meta_r;
            latch_prev_r <= latch_sync_r;
            oe_n_meta_r <= OUTPUT_ENABLE_N;
            oe_n_sync_r <= oe_n_meta_r;
            clr_n_meta_r <= SHIFT_CLEAR_N;
            clr_n_sync_r <= clr_n_meta_r;
        end
    end

    // Drain pin readback, used only for fault sensing
    always_ff @(posedge SYS_CLK or negedge RESETN) begin
        if (!RESETN) begin
            pin_meta_r <= '0;
            pin_sync_r <= '0;
        end else begin
            pin_meta_r <= DRAIN_I;
            pin_sync_r <= pin_meta_r;
        end
    end

    // Count how long the synced latch clock has stood high
    always_comb begin
        if (!latch_sync_r) begin
            high_cnt_nxt = '0;
        end else if (high_cnt_r != 4'hF) begin
            high_cnt_nxt = high_cnt_r + 4'h1;
        end else begin
            high_cnt_nxt = high_cnt_r;
        end
    end

    always_ff @(posedge SYS_CLK or negedge RESETN) begin
        if (!RESETN) begin
            high_cnt_r <= '0;
        end else begin
            high_cnt_r <= high_cnt_nxt;
        end
    end

    // A rising edge counts once the pulse has stood its least width
    assign latch_rise = latch_sync_r && (high_cnt_nxt == ssl_pkg::PULSE_MIN_CNT)
                        && (high_cnt_r != ssl_pkg::PULSE_MIN_CNT);

    // Capture: push at once, or hold the word while the buffer is full.
    // A further edge during a hold replaces the held word, newest wins.
    always_ff @(posedge SYS_CLK or negedge RESETN) begin
        if (!RESETN) begin
            cap_state_r <= ssl_pkg::CAP_IDLE;
            held_r <= '{bits: ssl_pkg::STORE_RESET};
        end else begin
            unique case (cap_state_r)
                ssl_pkg::CAP_IDLE: begin
                    if (latch_rise && !push_ready) begin
                        cap_state_r <= ssl_pkg::CAP_HOLD;
                        held_r <= '{bits: word_sync_r};
                    end
                end
                ssl_pkg::CAP_HOLD: begin
                    if (latch_rise) begin
                        held_r <= '{bits: word_sync_r};
                    end else if (push_ready) begin
                        cap_state_r <= ssl_pkg::CAP_IDLE;
                    end
                end
            endcase
        end
    end

    // Feed the buffer from the live edge or from the held word
    always_comb begin
        if (cap_state_r == ssl_pkg::CAP_HOLD) begin
            push_valid = !latch_rise;
            push_word = held_r;
        end else begin
            push_valid = latch_rise;
            push_word = '{bits: word_sync_r};
        end
    end

    ssl_fifo2 #(
        .WIDTH(W),
        .DEPTH(ssl_pkg::FIFO_DEPTH)
    ) u_buf (
        .clk(SYS_CLK),
        .rst_n(RESETN),
        .in_valid(push_valid),
        .in_ready(push_ready),
        .in_data(push_word),
        .out_valid(pop_valid),
        .out_ready(pop_ready),
        .out_data(pop_word)
    );

    // Storage takes a word every other cycle so the output stage has
    // settled on the previous one; this is the drain-side stall
    assign pop_ready = !store_busy_r;

    always_ff @(posedge SYS_CLK or negedge RESETN) begin
        if (!RESETN) begin
            store_busy_r <= 1'b0;
        end else begin
            store_busy_r <= pop_valid && pop_ready;
        end
    end

    // Storage register holds its word until the next latch load
    always_ff @(posedge SYS_CLK or negedge RESETN) begin
        if (!RESETN) begin
            storage_r <= ssl_pkg::STORE_RESET;
        end else if (pop_valid && pop_ready) begin
            storage_r <= pop_word.bits;
        end
    end

    // Output buffer: gated off by a high enable, else storage as is.
    // A one in the buffer drives the pin low to sink load current.
    always_ff @(posedge SYS_CLK or negedge RESETN) begin
        if (!RESETN) begin
            drain_oe_r <= '0;
        end else if (oe_n_sync_r) begin
            drain_oe_r <= '0;
        end else begin
            drain_oe_r <= storage_r;
        end
    end

    // An open-drain pin only ever pulls low
    always_ff @(posedge SYS_CLK or negedge RESETN) begin
        if (!RESETN) begin
            drain_o_r <= ssl_pkg::DRAIN_LEVEL;
        end else begin
            drain_o_r <= ssl_pkg::DRAIN_LEVEL;
        end
    end

    assign DRAIN_OE = drain_oe_r;
    assign DRAIN_O = drain_o_r;

    // Delay the drive to line up with the two-flop pin readback
    always_ff @(posedge SYS_CLK or negedge RESETN) begin
        if (!RESETN) begin
            oe_d1_r <= '0;
            oe_d2_r <= '0;
            oe_d3_r <= '0;
        end else begin
            oe_d1_r <= drain_oe_r;
            oe_d2_r <= oe_d1_r;
            oe_d3_r <= oe_d2_r;
        end
    end

    // Fault: pin still high although it has been pulled for a while
    genvar gi;
    generate
        for (gi = 0; gi < W; gi++) begin : g_fault
            always_ff @(posedge SYS_CLK or negedge RESETN) begin
                if (!RESETN) begin
                    fault_r[gi] <= 1'b0;
                end else begin
                    fault_r[gi] <= oe_d2_r[gi] & oe_d3_r[gi] & pin_sync_r[gi];
                end
            end
        end
    endgenerate

    assign DRAIN_FAULT = fault_r;

    chk_enable_off: assert property (
        @(posedge SYS_CLK) disable iff (!RESETN)
        oe_n_sync_r |=> drain_oe_r == '0)
        else $error("outputs driven while enable is high");

    chk_enable_pass: assert property (
        @(posedge SYS_CLK) disable iff (!RESETN)
        !oe_n_sync_r |=> drain_oe_r == $past(storage_r))
        else $error("outputs differ from storage while enabled");

    chk_drain_sink: assert property (
        @(posedge SYS_CLK) disable iff (!RESETN)
        drain_o_r == '0 && (drain_oe_r & ~oe_d1_r & ~$past(storage_r)) == '0)
        else $error("drain pin driven high or without a stored one");

    chk_latch_load: assert property (
        @(posedge SYS_CLK) disable iff (!RESETN)
        (latch_rise && cap_state_r == ssl_pkg::CAP_IDLE && push_ready
         && !pop_valid)
        |=> ##1 storage_r == $past(word_sync_r, 2))
        else $error("storage did not load latched word");

    chk_storage_hold: assert property (
        @(posedge SYS_CLK) disable iff (!RESETN)
        !(pop_valid && pop_ready) |=> $stable(storage_r))
        else $error("storage changed without a latch load");

    chk_clear_zero: assert property (
        @(posedge SYS_CLK) disable iff (!RESETN)
        (!clr_n_sync_r)[*3] |-> word_sync_r == '0)
        else $error("shift stage not empty during clear");

    chk_hold_drains: assert property (
        @(posedge SYS_CLK) disable iff (!RESETN)
        (cap_state_r == ssl_pkg::CAP_HOLD && !latch_rise)
        |-> ##[1:4] cap_state_r == ssl_pkg::CAP_IDLE)
        else $error("held latch word never entered buffer");

endmodule : ssl_top

// >>> tb/ssl_host_model.sv
// Host controller model: shifts bits on its own clock and pulses latch.
// Assumes the bench calls its tasks one at a time from a single process.
`timescale 1ns/1ps
module ssl_host_model (
    input wire logic sys_clk,
    output logic shift_clock,
    output logic serial_input,
    output logic latch_clock
);
    // Shift clock idles low between frames, data parked inverted
    initial begin
        shift_clock = 1'b0;
        serial_input = 1'b1;
        latch_clock = 1'b0;
    end

    // One 64 ns shift clock period, data set while the clock is low
    task automatic shift_bit(input logic b);
        serial_input = b;
        #32 shift_clock = 1'b1;
        #32 shift_clock = 1'b0;
        // Hold time is over, so the line no longer shows the bit
        serial_input = ~b;
    endtask : shift_bit

    // Latch pulse kept clear of the last shift edge by four cycles
    task automatic pulse_latch();
        repeat (4) @(negedge sys_clk);
        latch_clock = 1'b1;
        repeat (2) @(negedge sys_clk);
        latch_clock = 1'b0;
        repeat (2) @(negedge sys_clk);
    endtask : pulse_latch
endmodule : ssl_host_model

// >>> tb/tb.sv
// Self-checking bench for the output latch with a host model in front.
// Assumes pull-ups on the drain pins; a fault mask fakes an open load.
`timescale 1ns/1ps
module tb;
    logic sys_clk = 1'b0;
    logic resetn = 1'b1;
    logic shift_clear_n = 1'b1;
    logic output_enable_n = 1'b0;
    logic [7:0] fault_mask = 8'h00;
    logic shift_clock, serial_input, latch_clock, cascade_output;
    logic [7:0] drain_i, drain_o, drain_oe, drain_fault;
    logic [7:0] stage_m = 8'h00;
    int n_mismatch = 0;
    int cmp_count = 0;

    // Pin level: pulled up unless the driver sinks it
    assign drain_i = (drain_oe & drain_o) | ~drain_oe | fault_mask;

    // Clock generator
    always #25 sys_clk = ~sys_clk;

    ssl_host_model u_host (
        .sys_clk(sys_clk),
        .shift_clock(shift_clock),
        .serial_input(serial_input),
        .latch_clock(latch_clock)
    );

    ssl_top u_dut (
        .SYS_CLK(sys_clk),
        .RESETN(resetn),
        .SHIFT_CLOCK(shift_clock),
        .SERIAL_INPUT(serial_input),
        .SHIFT_CLEAR_N(shift_clear_n),
        .LATCH_CLOCK(latch_clock),
        .OUTPUT_ENABLE_N(output_enable_n),
        .DRAIN_I(drain_i),
        .DRAIN_O(drain_o),
        .DRAIN_OE(drain_oe),
        .CASCADE_OUTPUT(cascade_output),
        .DRAIN_FAULT(drain_fault)
    );

    task automatic check_word(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t got %h exp %h", $time, got, exp);
        end
    endtask : check_word

    task automatic check_bit(input logic got, input logic exp);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t got %h exp %h", $time, got, exp);
        end
    endtask : check_bit

    // Shift a word first bit first, tracking the stage in a model
    task automatic shift_word(input logic [7:0] w);
        for (int i = 7; i >= 0; i--) begin
            u_host.shift_bit(w[i]);
            if (shift_clear_n)
                stage_m = {stage_m[6:0], w[i]};
            check_bit(cascade_output, stage_m[7]);
        end
    endtask : shift_word

    // Latch, then give the sync and buffer path time to land
    task automatic latch_word();
        u_host.pulse_latch();
        repeat (8) @(negedge sys_clk);
    endtask : latch_word

    task automatic t_basic();
        shift_word(8'hA5);
        check_word(drain_oe, 8'h00);
        latch_word();
        check_word(drain_oe, 8'hA5);
        check_word(drain_o, 8'h00);
    endtask : t_basic

    // Second word pushes the first out of the cascade pin
    task automatic t_chain();
        shift_word(8'h3C);
        check_word(drain_oe, 8'hA5);
        latch_word();
        check_word(drain_oe, 8'h3C);
    endtask : t_chain

    task automatic t_enable();
        output_enable_n = 1'b1;
        repeat (4) @(negedge sys_clk);
        check_word(drain_oe, 8'h00);
        shift_word(8'hC3);
        latch_word();
        check_word(drain_oe, 8'h00);
        output_enable_n = 1'b0;
        repeat (4) @(negedge sys_clk);
        check_word(drain_oe, 8'hC3);
    endtask : t_enable

    // Shift edges while clear is low must leave the stage empty
    task automatic t_clear();
        shift_word(8'hFF);
        @(negedge sys_clk);
        shift_clear_n = 1'b0;
        stage_m = 8'h00;
        @(negedge sys_clk);
        check_bit(cascade_output, 1'b0);
        shift_word(8'hFF);
        @(negedge sys_clk);
        shift_clear_n = 1'b1;
        latch_word();
        check_word(drain_oe, 8'h00);
        shift_word(8'h81);
        latch_word();
        check_word(drain_oe, 8'h81);
    endtask : t_clear

    // Pin stuck high on a driven output shows up as a fault
    task automatic t_fault();
        fault_mask = 8'h01;
        repeat (5) @(negedge sys_clk);
        check_word(drain_fault, 8'h01);
        fault_mask = 8'h00;
        repeat (5) @(negedge sys_clk);
        check_word(drain_fault, 8'h00);
    endtask : t_fault

    task automatic t_reset();
        shift_word(8'h5A);
        @(negedge sys_clk);
        resetn = 1'b0;
        stage_m = 8'h00;
        repeat (2) @(negedge sys_clk);
        check_word(drain_oe, 8'h00);
        check_bit(cascade_output, 1'b0);
        resetn = 1'b1;
        shift_word(8'h96);
        latch_word();
        check_word(drain_oe, 8'h96);
    endtask : t_reset

    task automatic end_of_test();
        if (n_mismatch == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : end_of_test

    // Main sequence
    initial begin
        // Reset falls as a real event so the shift-clock flops, which see
        // no clock edge during reset, are cleared as well
        #1 resetn = 1'b0;
        repeat (3) @(negedge sys_clk);
        check_word(drain_oe, 8'h00);
        resetn = 1'b1;
        @(negedge sys_clk);
        t_basic();
        t_chain();
        t_enable();
        t_clear();
        t_fault();
        t_reset();
        end_of_test();
    end

    // Watchdog: the tests need about 10 us
    initial begin
        #100000;
        n_mismatch++;
        end_of_test();
    end
endmodule : tb
